// file: hw/sam_cmp_if.sv
`timescale 1ns/100ps
interface sam_cmp_if;
    import sam_pkg::*;
    sam_err_type pos_err;
    sam_err_type stop_lim;
    sam_err_type move_lim;
    logic moving;
    sam_err_type abs_err;
    logic over_stop;
    logic over_move;
    modport host (output pos_err, output stop_lim, output move_lim, output moving,
        input abs_err, input over_stop, input over_move);
    modport cmp (input pos_err, input stop_lim, input move_lim, input moving,
        output abs_err, output over_stop, output over_move);
endinterface

// file: hw/sam_err_cmp.sv
`timescale 1ns/100ps
`include "sam_map.svh"
module sam_err_cmp
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    sam_cmp_if.cmp cmp
);
    import sam_pkg::*;

    typedef struct packed
    {
        sam_err_type abs_err;
        logic over_stop;
        logic over_move;
    } sam_cmp_state_type;

    sam_cmp_state_type q_reg;
    sam_cmp_state_type q_next;
    sam_err_type mag;

    // ==================================================
    // Magnitude and limit compare
    always_comb
    begin
        // Most negative error maps to 2^23, which still fits unsigned
        mag = cmp.pos_err[`SAM_ERR_W-1] ? sam_err_type'(~cmp.pos_err + 24'h000001) : cmp.pos_err;
        q_next = q_reg;
        q_next.abs_err = mag;
        q_next.over_stop = !cmp.moving && (mag > cmp.stop_lim);
        q_next.over_move = cmp.moving && (mag > cmp.move_lim);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q_reg <= '0;
        else if (ce_i)
            q_reg <= q_next;
    end

    assign cmp.abs_err = q_reg.abs_err;
    assign cmp.over_stop = q_reg.over_stop;
    assign cmp.over_move = q_reg.over_move;

    // ==================================================
    // Checks
    a_abs_symmetric: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> cmp.abs_err == ($past(cmp.pos_err[23]) ? sam_err_type'(-$past(cmp.pos_err)) : $past(cmp.pos_err)))
        else $error("abs error not symmetric");
endmodule

// file: hw/sam_map.svh
`ifndef SAM_MAP_SVH
`define SAM_MAP_SVH
// ==================================================
// Register offsets (byte addresses)
`define SAM_OFF_CTRL 8'h00
`define SAM_OFF_STATUS 8'h04
`define SAM_OFF_MASK 8'h08
`define SAM_OFF_STOP_LIM 8'h0C
`define SAM_OFF_MOVE_LIM 8'h10
`define SAM_OFF_COMM_DIAG 8'h14
`define SAM_OFF_POS_ERR 8'h18
`define SAM_OFF_LIVE 8'h1C
// ==================================================
// Servo alarm status word bit positions
`define SAM_BIT_NOT_READY 0
`define SAM_BIT_FB_BREAK 1
`define SAM_BIT_UNEXP_READY 2
`define SAM_BIT_HOME_ABN 3
`define SAM_BIT_OVERCURRENT 4
`define SAM_BIT_STOP_ERR 5
`define SAM_BIT_MOVE_ERR 6
`define SAM_ALARM_W 7
// ==================================================
// Control bit positions and widths
`define SAM_BIT_CONTACTOR 0
`define SAM_ERR_W 24
// ==================================================
// Reset values
`define SAM_RST_CTRL 1'h0
`define SAM_RST_STATUS 7'h00
`define SAM_RST_MASK 7'h00
`define SAM_RST_STOP_LIM 24'h000100
`define SAM_RST_MOVE_LIM 24'h001000
// ==================================================
// Timing
`define SAM_CLK_KHZ 40000
`define SAM_READY_WAIT_US 1000
`define SAM_READY_WAIT_CYC ((`SAM_READY_WAIT_US * `SAM_CLK_KHZ) / 1000)
`define SAM_RELEASE_WAIT_US 1000
`define SAM_RELEASE_WAIT_CYC ((`SAM_RELEASE_WAIT_US * `SAM_CLK_KHZ) / 1000)
`define SAM_TMR_W 20
`endif

// file: hw/sam_monitor.sv
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`include "sam_map.svh"
module sam_monitor
#(
    parameter int unsigned READY_WAIT_CYC = `SAM_READY_WAIT_CYC,
    parameter int unsigned RELEASE_WAIT_CYC = `SAM_RELEASE_WAIT_CYC
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic amp_ready_in_i,
    output logic contactor_on_request_o,
    input wire logic grid_i,
    input wire logic home_done_i,
    input wire logic axis_moving_i,
    input wire sam_pkg::sam_err_type pos_err_i,
    input wire logic overcurrent_flag_i,
    input wire logic feedback_break_flag_i,
    input wire logic [7:0] coder_diag_i,
    output logic irq_o
);
    import sam_pkg::*;

    // ==================================================
    // State
    typedef struct packed
    {
        sam_state_type st;
        logic [`SAM_TMR_W-1:0] tmr;
        logic rdy_s1;
        logic rdy_s2;
        logic grid_s1;
        logic grid_s2;
        logic oc_s1;
        logic oc_s2;
        logic fb_s1;
        logic fb_s2;
        logic [7:0] diag_s1;
        logic [7:0] diag_s2;
        logic ack;
        logic [31:0] rdata;
        logic req;
        sam_alarm_type status;
        sam_alarm_type mask;
        sam_err_type stop_lim;
        sam_err_type move_lim;
    } sam_mon_state_type;

    sam_mon_state_type q_reg;
    sam_mon_state_type q_next;
    sam_alarm_type ev;
    sam_alarm_type clr;
    logic access;
    logic wr_stb;

    sam_cmp_if cmp_bus ();

    sam_err_cmp u_cmp
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .cmp(cmp_bus)
    );

    assign cmp_bus.pos_err = pos_err_i;
    assign cmp_bus.stop_lim = q_reg.stop_lim;
    assign cmp_bus.move_lim = q_reg.move_lim;
    assign cmp_bus.moving = axis_moving_i;

    // ==================================================
    // Helpers
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                r[i*8 +: 8] = wd[i*8 +: 8];
        end
        merge = r;
    endfunction

    // ==================================================
    // Next state
    always_comb
    begin
        q_next = q_reg;
        ev = '0;
        clr = '0;
        access = wb_cyc_i && wb_stb_i;
        // Writes land on the edge where the master sees ack
        wr_stb = access && wb_we_i && q_reg.ack;

        // Two flops on the ready, grid, overcurrent, feedback break and diag inputs
        q_next.rdy_s1 = amp_ready_in_i;
        q_next.rdy_s2 = q_reg.rdy_s1;
        q_next.grid_s1 = grid_i;
        q_next.grid_s2 = q_reg.grid_s1;
        q_next.oc_s1 = overcurrent_flag_i;
        q_next.oc_s2 = q_reg.oc_s1;
        q_next.fb_s1 = feedback_break_flag_i;
        q_next.fb_s2 = q_reg.fb_s1;
        q_next.diag_s1 = coder_diag_i;
        q_next.diag_s2 = q_reg.diag_s1;

        // Amplifier handshake
        if (q_reg.tmr != '1)
            q_next.tmr = q_reg.tmr + 20'h00001;
        case (q_reg.st)
            SAM_OFF:
            begin
                q_next.tmr = '0;
                if (q_reg.rdy_s2)
                    ev[`SAM_BIT_UNEXP_READY] = 1'b1;
                if (q_reg.req)
                    q_next.st = SAM_WAIT_ON;
            end
            SAM_WAIT_ON:
            begin
                if (!q_reg.req)
                begin
                    q_next.st = SAM_WAIT_OFF;
                    q_next.tmr = '0;
                end
                else if (q_reg.rdy_s2)
                    q_next.st = SAM_RUN;
                else if (q_reg.tmr == `SAM_TMR_W'(READY_WAIT_CYC - 1))
                    ev[`SAM_BIT_NOT_READY] = 1'b1;
            end
            SAM_RUN:
            begin
                q_next.tmr = '0;
                if (!q_reg.req)
                    q_next.st = SAM_WAIT_OFF;
                else if (!q_reg.rdy_s2)
                begin
                    // Drop in operation; park with timer past its limit to avoid a second report
                    ev[`SAM_BIT_NOT_READY] = 1'b1;
                    q_next.st = SAM_WAIT_ON;
                    q_next.tmr = '1;
                end
            end
            SAM_WAIT_OFF:
            begin
                if (q_reg.req)
                begin
                    q_next.st = SAM_WAIT_ON;
                    q_next.tmr = '0;
                end
                else if (!q_reg.rdy_s2)
                    q_next.st = SAM_OFF;
                else if (q_reg.tmr == `SAM_TMR_W'(RELEASE_WAIT_CYC - 1))
                    ev[`SAM_BIT_UNEXP_READY] = 1'b1;
            end
            default:
            begin
                q_next.st = SAM_OFF;
                q_next.tmr = '0;
            end
        endcase

        // Other alarm sources
        if (home_done_i && !q_reg.grid_s2)
            ev[`SAM_BIT_HOME_ABN] = 1'b1;
        if (cmp_bus.over_stop)
            ev[`SAM_BIT_STOP_ERR] = 1'b1;
        if (cmp_bus.over_move)
            ev[`SAM_BIT_MOVE_ERR] = 1'b1;
        if (q_reg.oc_s2)
            ev[`SAM_BIT_OVERCURRENT] = 1'b1;
        if (q_reg.fb_s2)
            ev[`SAM_BIT_FB_BREAK] = 1'b1;

        // Register writes
        if (wr_stb)
        begin
            if (hit(wb_adr_i, `SAM_OFF_CTRL) && wb_sel_i[0])
                q_next.req = wb_dat_i[`SAM_BIT_CONTACTOR];
            if (hit(wb_adr_i, `SAM_OFF_STATUS) && wb_sel_i[0])
                clr = wb_dat_i[`SAM_ALARM_W-1:0];
            if (hit(wb_adr_i, `SAM_OFF_MASK) && wb_sel_i[0])
                q_next.mask = wb_dat_i[`SAM_ALARM_W-1:0];
            if (hit(wb_adr_i, `SAM_OFF_STOP_LIM))
                q_next.stop_lim = sam_err_type'(merge({8'h00, q_reg.stop_lim}, wb_dat_i, wb_sel_i));
            if (hit(wb_adr_i, `SAM_OFF_MOVE_LIM))
                q_next.move_lim = sam_err_type'(merge({8'h00, q_reg.move_lim}, wb_dat_i, wb_sel_i));
        end

        // Sticky flags; a new event beats a clear in the same cycle
        q_next.status = (q_reg.status & ~clr) | ev;

        // Read data captured as ack rises, unmapped reads give zero
        q_next.ack = access && !q_reg.ack;
        if (access && !q_reg.ack)
        begin
            q_next.rdata = 32'h00000000;
            if (hit(wb_adr_i, `SAM_OFF_CTRL))
                q_next.rdata[`SAM_BIT_CONTACTOR] = q_reg.req;
            else if (hit(wb_adr_i, `SAM_OFF_STATUS))
                q_next.rdata[`SAM_ALARM_W-1:0] = q_reg.status;
            else if (hit(wb_adr_i, `SAM_OFF_MASK))
                q_next.rdata[`SAM_ALARM_W-1:0] = q_reg.mask;
            else if (hit(wb_adr_i, `SAM_OFF_STOP_LIM))
                q_next.rdata[23:0] = q_reg.stop_lim;
            else if (hit(wb_adr_i, `SAM_OFF_MOVE_LIM))
                q_next.rdata[23:0] = q_reg.move_lim;
            else if (hit(wb_adr_i, `SAM_OFF_COMM_DIAG))
                q_next.rdata[7:0] = q_reg.diag_s2;
            else if (hit(wb_adr_i, `SAM_OFF_POS_ERR))
                q_next.rdata[23:0] = cmp_bus.abs_err;
            else if (hit(wb_adr_i, `SAM_OFF_LIVE))
                q_next.rdata[4:0] = {q_reg.rdy_s2, q_reg.st};
        end
    end

    // ==================================================
    // Registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q_reg <= '0;
            q_reg.st <= SAM_OFF;
            q_reg.req <= `SAM_RST_CTRL;
            q_reg.status <= `SAM_RST_STATUS;
            q_reg.mask <= `SAM_RST_MASK;
            q_reg.stop_lim <= `SAM_RST_STOP_LIM;
            q_reg.move_lim <= `SAM_RST_MOVE_LIM;
        end
        else if (ce_i)
            q_reg <= q_next;
    end

    assign wb_ack_o = q_reg.ack;
    assign wb_dat_o = q_reg.rdata;
    assign contactor_on_request_o = q_reg.req;
    assign irq_o = |(q_reg.status & q_reg.mask);

    // ==================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ready_timeout: assert property (
        ce_i && q_reg.st == SAM_WAIT_ON && q_reg.req && !q_reg.rdy_s2
        && q_reg.tmr == `SAM_TMR_W'(READY_WAIT_CYC - 1) |=> q_reg.status[`SAM_BIT_NOT_READY])
        else $error("ready timeout not flagged");
    a_ready_drop: assert property (
        ce_i && q_reg.st == SAM_RUN && q_reg.req && !q_reg.rdy_s2
        |=> q_reg.status[`SAM_BIT_NOT_READY] && q_reg.st == SAM_WAIT_ON)
        else $error("ready drop not flagged");
    a_early_ready: assert property (
        ce_i && q_reg.st == SAM_OFF && q_reg.rdy_s2 |=> q_reg.status[`SAM_BIT_UNEXP_READY])
        else $error("early ready not flagged");
    a_stuck_ready: assert property (
        ce_i && q_reg.st == SAM_WAIT_OFF && !q_reg.req && q_reg.rdy_s2
        && q_reg.tmr == `SAM_TMR_W'(RELEASE_WAIT_CYC - 1) |=> q_reg.status[`SAM_BIT_UNEXP_READY])
        else $error("stuck ready not flagged");
    a_home_grid: assert property (
        ce_i && home_done_i && !q_reg.grid_s2 |=> q_reg.status[`SAM_BIT_HOME_ABN])
        else $error("homing grid miss not flagged");
    a_stop_error: assert property (
        ce_i && !axis_moving_i && (pos_err_i == 24'h000000) |=> !cmp_bus.over_stop)
        else $error("zero error flagged while stopped");
    a_move_error: assert property (
        ce_i && cmp_bus.over_move |=> q_reg.status[`SAM_BIT_MOVE_ERR])
        else $error("move error not flagged");
    a_overcurrent_bit: assert property (
        ce_i && overcurrent_flag_i ##1 ce_i [*3] |-> q_reg.status[`SAM_BIT_OVERCURRENT])
        else $error("overcurrent not in bit 4");
    a_feedback_bit: assert property (
        ce_i && feedback_break_flag_i ##1 ce_i [*3] |-> q_reg.status[`SAM_BIT_FB_BREAK])
        else $error("feedback break not in bit 1");
    a_flags_latched: assert property (
        ce_i && !wr_stb |=> (q_reg.status & $past(q_reg.status)) == $past(q_reg.status))
        else $error("alarm flag lost without clear");
    a_bus_ack: assert property (
        ce_i && access && !q_reg.ack |=> q_reg.ack ##1 !q_reg.ack || !ce_i)
        else $error("ack not single cycle");
    a_ack_idle: assert property (
        ce_i && !access |=> !wb_ack_o)
        else $error("ack without request");
    a_state_onehot: assert property ($onehot(q_reg.st))
        else $error("handshake state not one-hot");
    a_irq_masked: assert property ((q_reg.mask == 7'h00) |-> !irq_o)
        else $error("interrupt with all sources masked");

    // Limit compares checked from the raw error, not from the submodule's own magnitude
    a_stop_compare: assert property (
        ce_i && !axis_moving_i && !pos_err_i[23] && (pos_err_i > q_reg.stop_lim) |=> cmp_bus.over_stop)
        else $error("positive stop error missed");
    a_move_compare: assert property (
        ce_i && axis_moving_i && !pos_err_i[23] && (pos_err_i > q_reg.move_lim) |=> cmp_bus.over_move)
        else $error("positive move error missed");
    a_negative_stop: assert property (
        ce_i && !axis_moving_i && pos_err_i[23] && (sam_err_type'(24'h000000 - pos_err_i) > q_reg.stop_lim)
        |=> cmp_bus.over_stop)
        else $error("negative stop error missed");
    a_negative_move: assert property (
        ce_i && axis_moving_i && pos_err_i[23] && (sam_err_type'(24'h000000 - pos_err_i) > q_reg.move_lim)
        |=> cmp_bus.over_move)
        else $error("negative move error missed");
    a_stop_status: assert property (
        ce_i && cmp_bus.over_stop |=> q_reg.status[`SAM_BIT_STOP_ERR])
        else $error("stop error not flagged");
    a_stop_only_still: assert property (
        ce_i && axis_moving_i |=> !cmp_bus.over_stop)
        else $error("stop limit applied while moving");
    a_move_only_moving: assert property (
        ce_i && !axis_moving_i |=> !cmp_bus.over_move)
        else $error("move limit applied while stopped");
    a_run_needs_ready: assert property (
        ce_i && q_reg.st == SAM_WAIT_ON && !q_reg.rdy_s2 |=> q_reg.st != SAM_RUN)
        else $error("run entered without ready");
    // A clear must win only when no event lands in the same cycle
    a_status_clear: assert property (
        ce_i && wr_stb && hit(wb_adr_i, `SAM_OFF_STATUS) && wb_sel_i[0] && (ev == 7'h00)
        |=> (q_reg.status & $past(wb_dat_i[`SAM_ALARM_W-1:0])) == 7'h00)
        else $error("written ones did not clear flags");
    a_request_write: assert property (
        ce_i && wr_stb && hit(wb_adr_i, `SAM_OFF_CTRL) && wb_sel_i[0]
        |=> contactor_on_request_o == $past(wb_dat_i[`SAM_BIT_CONTACTOR]))
        else $error("contactor request not written");

    c_run_reached: cover property (q_reg.st == SAM_WAIT_ON ##1 q_reg.st == SAM_RUN);
    c_home_alarm: cover property ($rose(q_reg.status[`SAM_BIT_HOME_ABN]));
    c_irq_raised: cover property ($rose(irq_o));
    c_status_clear: cover property ($fell(q_reg.status[`SAM_BIT_STOP_ERR]));
    c_unexp_ready: cover property ($rose(q_reg.status[`SAM_BIT_UNEXP_READY]));
endmodule

// file: hw/sam_pkg.sv
package sam_pkg;
    // ==================================================
    // Handshake states, one-hot
    typedef enum logic [3:0]
    {
        SAM_OFF = 4'h1,
        SAM_WAIT_ON = 4'h2,
        SAM_RUN = 4'h4,
        SAM_WAIT_OFF = 4'h8
    } sam_state_type;

    typedef logic [23:0] sam_err_type;
    typedef logic [6:0] sam_alarm_type;
endpackage

// file: verification/sam_amp_model.sv
`timescale 1ns/100ps
// ==================================================
// Amplifier model: 0 follows the request, 1 never ready, 2 stuck ready
module sam_amp_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic contactor_on_request_i,
    input wire logic [1:0] mode_i,
    output logic amp_ready_o
);
    logic [2:0] dly_reg;

    // Three-cycle delay stands in for the contactor closing and opening
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dly_reg <= 3'h0;
        end
        else
        begin
            dly_reg <= {dly_reg[1:0], contactor_on_request_i};
        end
    end

    assign amp_ready_o = (mode_i == 2'h2) ? 1'b1 : (mode_i == 2'h1) ? 1'b0 : dly_reg[2];
endmodule

// file: verification/tb_top.sv
`timescale 1ns/100ps
`include "sam_map.svh"
module tb_top;
    import sam_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic ack, req, rdy, irq;
    logic grid = 1'b0, home = 1'b0, mov = 1'b0, oc = 1'b0, fb = 1'b0;
    logic [1:0] mode = 2'h0;
    sam_err_type perr = 24'h0;
    int miscompares = 0;
    int cmp_count = 0;
    logic ev_mov[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    sam_err_type ev_err[6] = '{24'h000101, 24'hFFFEFF, 24'h000100, 24'h000101, 24'h001000, 24'hFFEFFF};
    logic [31:0] ev_exp[6] = '{32'h20, 32'h20, 32'h0, 32'h0, 32'h0, 32'h40};

    always #12.5 clk_i = ~clk_i;

    sam_monitor #(.READY_WAIT_CYC(8), .RELEASE_WAIT_CYC(8)) sam_monitor_i
    (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .amp_ready_in_i(rdy), .contactor_on_request_o(req),
        .grid_i(grid), .home_done_i(home), .axis_moving_i(mov), .pos_err_i(perr),
        .overcurrent_flag_i(oc), .feedback_break_flag_i(fb), .coder_diag_i(8'hA5), .irq_o(irq)
    );

    sam_amp_model sam_amp_model_i
    (
        .clk_i(clk_i), .rst_i(rst_i), .contactor_on_request_i(req), .mode_i(mode), .amp_ready_o(rdy)
    );

    // ==================================================
    // Bus access and comparison
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until ack is sampled high; only the watchdog ends a dead wait
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Status read, then every flag cleared by writing ones
    task automatic st(input logic [31:0] exp);
        rd(`SAM_OFF_STATUS, exp);
        wr(`SAM_OFF_STATUS, 32'h7F);
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==================================================
    // Watchdog sized well above the few hundred cycles the tests need
    initial
    begin
        #(25 * 20000);
        miscompares++;
        close_out;
    end

    // ==================================================
    // Tests
    initial
    begin
        cyc_wait(5);
        rst_i <= 1'b0;
        rd(`SAM_OFF_STOP_LIM, 32'h100);
        rd(`SAM_OFF_MOVE_LIM, 32'h1000);
        wr(`SAM_OFF_STOP_LIM, 32'hFF123456);
        rd(`SAM_OFF_STOP_LIM, 32'h123456);
        wr(`SAM_OFF_STOP_LIM, 32'h100);
        wr(`SAM_OFF_MOVE_LIM, 32'h00654321);
        rd(`SAM_OFF_MOVE_LIM, 32'h654321);
        wr(`SAM_OFF_MOVE_LIM, 32'h1000);
        rd(`SAM_OFF_MASK, 32'h0);
        wr(8'h40, 32'hFFFF);
        rd(8'h40, 32'h0);
        rd(`SAM_OFF_COMM_DIAG, 32'hA5);
        st(32'h0);
        mode <= 2'h1;
        wr(`SAM_OFF_CTRL, 32'h1);
        cyc_wait(20);
        st(32'h01);
        wr(`SAM_OFF_CTRL, 32'h0);
        // Model delay line still holds the old request; let it drain before it follows again
        cyc_wait(10);
        mode <= 2'h0;
        wr(`SAM_OFF_CTRL, 32'h1);
        cyc_wait(12);
        rd(`SAM_OFF_LIVE, 32'h14);
        check(req, 1'b1);
        st(32'h0);
        mode <= 2'h1;
        cyc_wait(10);
        st(32'h01);
        wr(`SAM_OFF_CTRL, 32'h0);
        cyc_wait(12);
        mode <= 2'h2;
        cyc_wait(10);
        mode <= 2'h0;
        cyc_wait(10);
        st(32'h04);
        wr(`SAM_OFF_CTRL, 32'h1);
        cyc_wait(12);
        st(32'h0);
        mode <= 2'h2;
        wr(`SAM_OFF_CTRL, 32'h0);
        cyc_wait(20);
        mode <= 2'h0;
        cyc_wait(10);
        st(32'h04);
        @(posedge clk_i) home <= 1'b1;
        @(posedge clk_i) home <= 1'b0;
        cyc_wait(5);
        st(32'h08);
        grid <= 1'b1;
        cyc_wait(4);
        @(posedge clk_i) home <= 1'b1;
        @(posedge clk_i) home <= 1'b0;
        cyc_wait(5);
        st(32'h0);
        for (int i = 0; i < 6; i++)
        begin
            mov <= ev_mov[i];
            perr <= ev_err[i];
            cyc_wait(5);
            rd(`SAM_OFF_POS_ERR, ev_err[i][23] ? {8'h0, -ev_err[i]} : {8'h0, ev_err[i]});
            perr <= 24'h0;
            cyc_wait(5);
            st(ev_exp[i]);
        end
        oc <= 1'b1;
        cyc_wait(6);
        check(irq, 1'b0);
        wr(`SAM_OFF_MASK, 32'h10);
        cyc_wait(2);
        check(irq, 1'b1);
        oc <= 1'b0;
        cyc_wait(4);
        st(32'h10);
        cyc_wait(2);
        check(irq, 1'b0);
        fb <= 1'b1;
        cyc_wait(6);
        fb <= 1'b0;
        cyc_wait(4);
        st(32'h02);
        close_out;
    end
endmodule
